/* bench/pci_master_burst_read_64_bench.sv */
module pci_master_burst_read_64_bench
  import burst_read_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [15:0] len;
    logic        wide;
    logic        slow;
    logic        stall;
  } row_t;
  row_t rows [4] = '{
    '{32'h0000_1000, 4'h6, 16'h0003, 1'h1, 1'h0, 1'h0},
    '{32'hFFFF_FFF8, 4'hC, 16'h0001, 1'h1, 1'h1, 1'h0},
    '{32'h0000_2000, 4'hE, 16'h0005, 1'h0, 1'h1, 1'h0},
    '{32'h8000_0040, 4'h6, 16'h0028, 1'h1, 1'h0, 1'h1}
  };
  logic                mclk, rst, req_n, rdy, wide, slow, gpulse, saw_frame;
  logic [ADDR_W-1:0]   addr;
  logic [CMD_W-1:0]    cmd;
  logic [CNT_W-1:0]    beats, count;
  logic [CODE_W-1:0]   code;
  logic [1:0]          cause;
  logic [DATA_W-1:0]   ldata, ad, t_ad;
  logic [BEN_W-1:0]    cben;
  logic                grant_n, lvalid, reqn, framen, framen_oe, req64n, irdyn, irdyn_oe;
  logic                par_oe, ad_oe, cben_oe, gntn, devseln, trdyn, ack64n;
  logic [DATA_W-1:0]   got [$];
  int                  bad_count, check_count;
  // Pull-ups on control lines; data lines come from whoever drives
  wire logic              framen_w = framen_oe ? framen : 1'h1;
  wire logic              irdyn_w  = irdyn_oe ? irdyn : 1'h1;
  wire logic [DATA_W-1:0] ad_w     = ad_oe ? ad : t_ad;

  pci_master_burst_read_64 i_dut (
    .i_mclk(mclk), .i_rst(rst), .i_local_wide_request_n(req_n), .i_local_addr(addr),
    .i_local_cmd_byteen_in(cmd), .i_requested_beats(beats), .i_local_master_ready_n(1'h0),
    .o_local_grant_n(grant_n), .o_local_master_state_code(code), .o_local_end_cause(cause),
    .o_remaining_beats_count(count), .o_local_data(ldata), .o_local_data_valid(lvalid),
    .i_local_data_ready(rdy), .o_reqn(reqn), .i_gntn(gntn), .i_framen(framen_w),
    .o_framen(framen), .o_framen_oe(framen_oe), .o_req64n(req64n), .o_irdyn(irdyn),
    .o_irdyn_oe(irdyn_oe), .o_par_oe(par_oe), .i_irdyn(irdyn_w), .i_trdyn(trdyn),
    .i_devseln(devseln), .i_ack64n(ack64n), .i_ad(ad_w), .o_ad(ad), .o_ad_oe(ad_oe),
    .o_cben(cben), .o_cben_oe(cben_oe));
  pci_target_model i_target (
    .i_mclk(mclk), .i_rst(rst), .i_reqn(reqn), .i_framen(framen_w), .i_irdyn(irdyn_w),
    .i_wide(wide), .i_slow(slow), .i_grant_pulse(gpulse), .o_gntn(gntn),
    .o_devseln(devseln), .o_trdyn(trdyn), .o_ack64n(ack64n), .o_ad(t_ad));

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (lvalid === 1'h1 && rdy) got.push_back(ldata);
    saw_frame <= (framen_oe === 1'h1) || (gpulse && saw_frame);
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wait_code(input logic [CODE_W-1:0] c);
    int n;
    n = 0;
    #1;
    while (code !== c) begin
      #10;
      n++;
      if (n > 600) begin
        bad_count++;
        conclude();
      end
    end
  endtask
  task automatic run_row(input row_t r);
    logic [63:0] exp;
    got.delete();
    @(posedge mclk);
    wide  <= r.wide;
    slow  <= r.slow;
    rdy   <= !r.stall;
    req_n <= 1'h0;
    addr  <= r.addr;
    cmd   <= r.cmd;
    beats <= r.len;
    #1;
    check("reqn early", reqn, 1'h1);
    @(posedge mclk);
    #1;
    check("reqn", reqn, 1'h0);
    wait_code(CODE_LOAD);
    check("grant", grant_n, 1'h0);
    check("count", count, r.len);
    @(posedge mclk);
    req_n <= 1'h1;
    wait_code(CODE_XACT);
    check("frame", {framen_oe, framen, req64n, ad_oe, cben_oe}, 5'h13);
    check("addr", ad[31:0], r.addr);
    check("cmd", cben[3:0], r.cmd);
    if (r.stall) begin
      repeat (100) @(posedge mclk);
      rdy <= 1'h1;
    end
    wait_code(CODE_TERM);
    check("term", {framen_oe, ad_oe, cben_oe, irdyn, count}, {4'h1, 16'h0000});
    check("cause", cause, END_NORMAL);
    check("target", {devseln, trdyn}, 2'h3);
    check("reqn end", reqn, 1'h1);
    @(posedge mclk);
    #1;
    check("release", {irdyn_oe, par_oe}, 2'h0);
    for (int n = 0; n < 10 && grant_n !== 1'h1; n++) #10;
    check("grant end", grant_n, 1'h1);
    for (int n = 0; n < 200 && got.size() < r.len; n++) #10;
    check("words", got.size(), r.len);
    foreach (got[k]) begin
      exp = {r.wide ? 32'hAA00_0000 + k : 32'h0000_0000, 32'h5500_0000 + k};
      check("data", got[k], exp);
    end
  endtask

  initial begin
    rst = 1'h1;
    req_n = 1'h1;
    addr = 32'h0000_0000;
    cmd = 4'h0;
    beats = 16'h0000;
    rdy = 1'h1;
    wide = 1'h1;
    slow = 1'h0;
    gpulse = 1'h0;
    repeat (10) @(posedge mclk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("burst %0d done", i);
    end
    @(posedge mclk);
    req_n <= 1'h0;
    wait_code(CODE_XACT);
    @(posedge mclk);
    rst   <= 1'h1;
    req_n <= 1'h1;
    @(posedge mclk);
    #1;
    check("rst pins", {reqn, grant_n, framen, req64n, irdyn}, 5'h1F);
    check("rst oe", {framen_oe, irdyn_oe, par_oe, ad_oe, cben_oe, lvalid}, 6'h00);
    check("rst state", {code, cause, count}, 22'h00_0000);
    @(posedge mclk);
    rst <= 1'h0;
    $display("reset test done");
    @(posedge mclk);
    gpulse    <= 1'h1;
    req_n     <= 1'h0;
    repeat (30) @(posedge mclk);
    req_n <= 1'h1;
    repeat (10) @(posedge mclk);
    #1;
    check("refused", {saw_frame, grant_n, code}, {2'h1, CODE_IDLE});
    check("codes", {CODE_LOAD != CODE_XACT, CODE_XACT != CODE_TERM}, 2'h3);
    $display("refusal test done");
    conclude();
  end
endmodule // pci_master_burst_read_64_bench

/* bench/pci_target_model.sv */
module pci_target_model
  import burst_read_pkg::*;
(
  // Clock and reset
  input  wire logic                         i_mclk,
  input  wire logic                         i_rst,
  // Resolved bus wires and scenario controls
  input  wire logic                         i_reqn,
  input  wire logic                         i_framen,
  input  wire logic                         i_irdyn,
  input  wire logic                         i_wide,
  input  wire logic                         i_slow,
  input  wire logic                         i_grant_pulse,
  // Arbiter and target pins
  output logic                              o_gntn,
  output logic                              o_devseln,
  output logic                              o_trdyn,
  output logic                              o_ack64n,
  output logic [burst_read_pkg::DATA_W-1:0] o_ad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        active;
  logic [1:0]  gcnt;
  logic [31:0] beat;
  logic [63:0] idle_pat = 64'h5A5A_5A5A_5A5A_5A5A;
  // Released lines flip every cycle; upper half always driven
  assign o_ad = active ? {32'hAA00_0000 + beat, 32'h5500_0000 + beat} : idle_pat;
  always_ff @(posedge i_mclk) begin
    idle_pat <= ~idle_pat;
    if (i_rst) begin
      gcnt      <= 2'h0;
      o_gntn    <= 1'h1;
      active    <= 1'h0;
      o_devseln <= 1'h1;
      o_trdyn   <= 1'h1;
      o_ack64n  <= 1'h1;
      beat      <= 32'h0000_0000;
    end else begin
      gcnt   <= i_reqn ? 2'h0 : gcnt + {1'h0, gcnt != 2'h3};
      o_gntn <= i_reqn | (i_grant_pulse & (gcnt >= 2'h2));
      if (!active && !i_framen) begin
        active    <= 1'h1;
        beat      <= 32'h0000_0000;
        o_devseln <= 1'h0;
        o_ack64n  <= !i_wide;
      end else if (active && i_framen) begin
        // Master has released frame: end the transfer and let go
        active    <= 1'h0;
        o_trdyn   <= 1'h1;
        o_devseln <= 1'h1;
        o_ack64n  <= 1'h1;
      end else if (active && !o_trdyn && !i_irdyn) begin
        beat    <= beat + 32'h0000_0001;
        o_trdyn <= i_slow;
      end else if (active) begin
        o_trdyn <= 1'h0;
      end
    end
  end
endmodule // pci_target_model

/* design/beat_fifo.sv */
module beat_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // Fill and drain sides
  stream_if.sink    wr,
  stream_if.source  rd
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("beat_fifo depth must be a power of two");
    end
  end

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fstate_t;

  fstate_t          st;
  fstate_t          next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign wr.ready = (st.cnt != (AW+1)'(DEPTH));
  assign rd.valid = (st.cnt != '0);
  assign rd.data  = mem[st.rp];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wp = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
    if (push) begin
      mem[st.wp] <= wr.data;
    end
  end

  fifo_bound_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    st.cnt <= (AW+1)'(DEPTH))
    else $error("fifo count past depth");
endmodule // beat_fifo

/* design/burst_read_pkg.sv */
package burst_read_pkg;
  localparam int          ADDR_W       = 32;
  localparam int          DATA_W       = 64;
  localparam int          CMD_W        = 4;
  localparam int          BEN_W        = 8;
  localparam int          CNT_W        = 16;
  localparam int          CODE_W       = 4;
  localparam int          FIFO_DEPTH   = 32;
  localparam int          HALF_W       = 32;
  localparam logic [3:0]  CODE_IDLE    = 4'h0;
  localparam logic [3:0]  CODE_LOAD    = 4'h1;
  localparam logic [3:0]  CODE_XACT    = 4'h2;
  localparam logic [3:0]  CODE_TERM    = 4'h3;
  localparam logic [1:0]  END_NONE     = 2'h0;
  localparam logic [1:0]  END_NORMAL   = 2'h1;
  localparam logic [1:0]  END_ABORT    = 2'h2;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_REQ  = 7'b000_0010,
    ST_GNT  = 7'b000_0100,
    ST_LOAD = 7'b000_1000,
    ST_ADDR = 7'b001_0000,
    ST_DATA = 7'b010_0000,
    ST_TURN = 7'b100_0000
  } mstate_t;
endpackage

/* design/pci_master_burst_read_64.sv */
// Contract
// - Turnaround releases frame, address/data, command lines
// - Turnaround drops irdyn, zeroes remaining beat count
// - Both ready last beat gives termination, normal
// - Idle after turnaround releases irdyn and parity
// - Narrow burst ignores upper data half
// - Assert reqn one cycle after local request
// - Grant idle bus locally when gntn asserted
// - Request and grant seen: load state, latch
// - Granted after load: assert framen and req64n
// - Address phase drives address and command
// - Address phase shows bus transaction state
// - Latching loads remaining beats with length
// - Frame without local request drops reqn
// - Local grant follows gntn after start
module pci_master_burst_read_64
  import burst_read_pkg::*;
(
  // Clock and reset
  input  wire  logic                               i_mclk,
  input  wire  logic                               i_rst,
  // Local master request side
  input  wire  logic                               i_local_wide_request_n,
  input  wire  logic [burst_read_pkg::ADDR_W-1:0]  i_local_addr,
  input  wire  logic [burst_read_pkg::CMD_W-1:0]   i_local_cmd_byteen_in,
  input  wire  logic [burst_read_pkg::CNT_W-1:0]   i_requested_beats,
  input  wire  logic                               i_local_master_ready_n,
  output logic                                     o_local_grant_n,
  output logic [burst_read_pkg::CODE_W-1:0]        o_local_master_state_code,
  output logic [1:0]                               o_local_end_cause,
  output logic [burst_read_pkg::CNT_W-1:0]         o_remaining_beats_count,
  // Local read data
  output logic [burst_read_pkg::DATA_W-1:0]        o_local_data,
  output logic                                     o_local_data_valid,
  input  wire  logic                               i_local_data_ready,
  // PCI arbitration
  output logic                                     o_reqn,
  input  wire  logic                               i_gntn,
  // PCI control pins
  input  wire  logic                               i_framen,
  output logic                                     o_framen,
  output logic                                     o_framen_oe,
  output logic                                     o_req64n,
  output logic                                     o_irdyn,
  output logic                                     o_irdyn_oe,
  output logic                                     o_par_oe,
  input  wire  logic                               i_irdyn,
  input  wire  logic                               i_trdyn,
  input  wire  logic                               i_devseln,
  input  wire  logic                               i_ack64n,
  // PCI address/data and command
  input  wire  logic [burst_read_pkg::DATA_W-1:0]  i_ad,
  output logic [burst_read_pkg::DATA_W-1:0]        o_ad,
  output logic                                     o_ad_oe,
  output logic [burst_read_pkg::BEN_W-1:0]         o_cben,
  output logic                                     o_cben_oe
);
  import burst_read_pkg::*;

  // Beats that can still land after irdyn rises, behind the pin synchronisers
  localparam int IN_FLIGHT = 4;
  localparam int HELD_W    = $clog2(FIFO_DEPTH) + 1;

  typedef struct packed {
    logic [1:0]        s1_framen;
    logic [1:0]        s1_irdyn;
    logic [1:0]        s1_trdyn;
    logic [1:0]        s1_devseln;
    logic [1:0]        s1_ack64n;
    logic [1:0]        s1_gntn;
    logic [1:0]        s1_rdyn;
    logic [DATA_W-1:0] ad_s0;
    logic [DATA_W-1:0] ad_s1;
  } sync_t;

  typedef struct packed {
    mstate_t           fsm;
    logic              reqn;
    logic              lgntn;
    logic              req_seen;
    logic              framen;
    logic              framen_oe;
    logic              req64n;
    logic              irdyn;
    logic              irdyn_oe;
    logic              par_oe;
    logic              ad_oe;
    logic              cben_oe;
    logic              wide;
    logic [ADDR_W-1:0] addr;
    logic [CMD_W-1:0]  cmd;
    logic [CNT_W-1:0]  beats;
    logic [CODE_W-1:0] code;
    logic [1:0]        cause;
    logic              prev_both;
    logic              prev_lreq;
    logic              prev_lgnt;
    logic              irdyn_d1;
    logic              irdyn_d2;
    logic [HELD_W-1:0] held;
  } state_t;

  sync_t  sy;
  state_t st;
  state_t next_st;
  logic   frame_s;
  logic   irdy_s;
  logic   trdy_s;
  logic   devsel_s;
  logic   ack64_s;
  logic   gnt_s;
  logic   rdy_s;
  logic   beat_done;
  logic   fifo_ready;
  logic   push_beat;
  logic   pop_word;
  logic   room;
  logic [DATA_W-1:0] beat_data;

  stream_if #(.WIDTH(DATA_W)) fill ();
  stream_if #(.WIDTH(DATA_W)) drain ();

  // Two-stage synchronisers on PCI pins and local ready
  always_ff @(posedge i_mclk) begin
    sy.s1_framen  <= {sy.s1_framen[0], i_framen};
    sy.s1_irdyn   <= {sy.s1_irdyn[0], i_irdyn};
    sy.s1_trdyn   <= {sy.s1_trdyn[0], i_trdyn};
    sy.s1_devseln <= {sy.s1_devseln[0], i_devseln};
    sy.s1_ack64n  <= {sy.s1_ack64n[0], i_ack64n};
    sy.s1_gntn    <= {sy.s1_gntn[0], i_gntn};
    sy.s1_rdyn    <= {sy.s1_rdyn[0], i_local_master_ready_n};
    sy.ad_s0      <= i_ad;
    sy.ad_s1      <= sy.ad_s0;
  end

  assign frame_s   = ~sy.s1_framen[1];
  assign irdy_s    = ~sy.s1_irdyn[1];
  assign trdy_s    = ~sy.s1_trdyn[1];
  assign devsel_s  = ~sy.s1_devseln[1];
  assign ack64_s   = ~sy.s1_ack64n[1];
  assign gnt_s     = ~sy.s1_gntn[1];
  assign rdy_s     = ~sy.s1_rdyn[1];
  assign fifo_ready = fill.ready;
  // Own irdyn delayed twice to line up with the synchronised trdyn
  assign beat_done = (st.fsm == ST_DATA) && trdy_s && !st.irdyn_d2 && devsel_s;
  // Narrow burst keeps only the low half
  assign beat_data = st.wide ? sy.ad_s1
                             : {{HALF_W{1'b0}}, sy.ad_s1[HALF_W-1:0]};

  assign fill.data  = beat_data;
  assign fill.valid = beat_done;

  beat_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .wr     (fill),
    .rd     (drain)
  );

  assign o_local_data       = drain.data;
  assign o_local_data_valid = drain.valid;
  assign drain.ready        = i_local_data_ready;
  assign push_beat          = beat_done && fifo_ready;
  assign pop_word           = drain.valid && drain.ready;
  // Leave room for the beats already in flight
  assign room               = st.held <= HELD_W'(FIFO_DEPTH - IN_FLIGHT);

  always_comb begin
    next_st           = st;
    next_st.prev_lreq = !i_local_wide_request_n;
    next_st.prev_lgnt = !st.lgntn;
    next_st.prev_both = 1'b0;
    next_st.irdyn_d1  = st.irdyn;
    next_st.irdyn_d2  = st.irdyn_d1;
    next_st.held      = st.held + HELD_W'(push_beat) - HELD_W'(pop_word);
    // Bus request one cycle after the local request
    if (st.fsm == ST_IDLE && !i_local_wide_request_n) begin
      next_st.reqn = 1'b0;
    end
    // Drop bus request once framing without a further local request
    if (frame_s && !st.prev_lreq && st.fsm != ST_IDLE) begin
      next_st.reqn = 1'b1;
    end
    unique case (st.fsm)
      ST_IDLE: begin
        next_st.irdyn_oe = 1'b0;
        next_st.par_oe   = 1'b0;
        if (!i_local_wide_request_n) begin
          next_st.fsm = ST_REQ;
        end
      end
      ST_REQ: begin
        if (gnt_s && !frame_s && !irdy_s) begin
          next_st.lgntn = 1'b0;
          next_st.fsm   = ST_GNT;
        end
      end
      ST_GNT: begin
        if (st.prev_lreq && !st.lgntn) begin
          next_st.code  = CODE_LOAD;
          next_st.addr  = i_local_addr;
          next_st.cmd   = i_local_cmd_byteen_in;
          next_st.beats = i_requested_beats;
          next_st.fsm   = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (gnt_s && st.code == CODE_LOAD) begin
          next_st.framen    = 1'b0;
          next_st.framen_oe = 1'b1;
          next_st.req64n    = 1'b0;
          next_st.ad_oe     = 1'b1;
          next_st.cben_oe   = 1'b1;
          next_st.par_oe    = 1'b1;
          next_st.irdyn_oe  = 1'b1;
          next_st.code      = CODE_XACT;
          next_st.fsm       = ST_ADDR;
        end else begin
          next_st.lgntn = 1'b1;
          next_st.code  = CODE_IDLE;
          next_st.fsm   = ST_IDLE;
        end
      end
      ST_ADDR: begin
        next_st.lgntn  = !gnt_s;
        next_st.ad_oe  = 1'b0;
        next_st.req64n = 1'b1;
        next_st.irdyn  = !(rdy_s && room);
        next_st.fsm    = ST_DATA;
      end
      ST_DATA: begin
        next_st.lgntn = !gnt_s;
        if (devsel_s) begin
          next_st.wide = ack64_s;
        end
        next_st.irdyn = !(rdy_s && room);
        if (beat_done) begin
          next_st.beats = st.beats - CNT_W'(1);
          if (st.beats <= CNT_W'(2)) begin
            next_st.framen = 1'b1;
          end
          if (st.beats <= CNT_W'(1)) begin
            next_st.prev_both = 1'b1;
            next_st.fsm       = ST_TURN;
          end
        end
      end
      ST_TURN: begin
        next_st.framen_oe = 1'b0;
        next_st.ad_oe     = 1'b0;
        next_st.cben_oe   = 1'b0;
        next_st.irdyn     = 1'b1;
        next_st.beats     = '0;
        if (st.prev_both) begin
          next_st.code  = CODE_TERM;
          next_st.cause = END_NORMAL;
        end
        next_st.lgntn = 1'b1;
        next_st.fsm   = ST_IDLE;
      end
      default: begin
        next_st = '0;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st        <= '0;
      st.fsm    <= ST_IDLE;
      st.reqn   <= 1'b1;
      st.lgntn  <= 1'b1;
      st.framen <= 1'b1;
      st.req64n <= 1'b1;
      st.irdyn  <= 1'b1;
      st.code   <= CODE_IDLE;
      st.cause  <= END_NONE;
    end else begin
      st <= next_st;
    end
  end

  assign o_reqn                    = st.reqn;
  assign o_local_grant_n           = st.lgntn;
  assign o_local_master_state_code = st.code;
  assign o_local_end_cause         = st.cause;
  assign o_remaining_beats_count   = st.beats;
  assign o_framen                  = st.framen;
  assign o_framen_oe               = st.framen_oe;
  assign o_req64n                  = st.req64n;
  assign o_irdyn                   = st.irdyn;
  assign o_irdyn_oe                = st.irdyn_oe;
  assign o_par_oe                  = st.par_oe;
  assign o_ad                      = {{HALF_W{1'b0}}, st.addr};
  assign o_ad_oe                   = st.ad_oe;
  assign o_cben                    = {{(BEN_W-CMD_W){1'b0}}, st.cmd};
  assign o_cben_oe                 = st.cben_oe;

  codes_distinct_a: assert property (@(posedge i_mclk)
    CODE_LOAD != CODE_XACT && CODE_XACT != CODE_TERM && CODE_LOAD != CODE_TERM)
    else $error("state codes not distinct");
  turn_release_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    st.fsm == ST_TURN |=> !o_framen_oe && !o_ad_oe && !o_cben_oe)
    else $error("lines not released after turnaround");
  turn_zero_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    st.fsm == ST_TURN |=> o_irdyn && o_remaining_beats_count == '0)
    else $error("irdyn or count wrong after turnaround");
  normal_end_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    st.fsm == ST_TURN && st.prev_both |=>
      o_local_master_state_code == CODE_TERM && o_local_end_cause == END_NORMAL)
    else $error("normal termination not reported");
  idle_release_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    st.fsm == ST_TURN |=> ##1 !o_irdyn_oe && !o_par_oe)
    else $error("irdyn or par still driven in idle");
  bus_request_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    st.fsm == ST_IDLE && !i_local_wide_request_n |=> !o_reqn)
    else $error("reqn not asserted after local request");
  load_latch_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    st.fsm == ST_GNT && st.prev_lreq && !st.lgntn |=>
      o_local_master_state_code == CODE_LOAD
      && o_remaining_beats_count == $past(i_requested_beats))
    else $error("load state or beat count wrong");
  start_frame_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    st.fsm == ST_LOAD && gnt_s |=> !o_framen && !o_req64n
      && o_local_master_state_code == CODE_XACT && o_ad_oe)
    else $error("address phase not started");
  beat_drop_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    beat_done |-> fifo_ready)
    else $error("beat arrived with fifo full");
endmodule // pci_master_burst_read_64

/* design/stream_if.sv */
interface stream_if #(parameter int WIDTH = 64);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface
